// File: verilog/boot_seq_params.svh
`ifndef BOOT_SEQ_PARAMS_SVH
`define BOOT_SEQ_PARAMS_SVH
// ----------------------------------------
// configuration pin fields
// ----------------------------------------
`define CFG_WIDTH 12
`define PRI_ZERO_BIT 11
`define PRI_FEEDBACK_SOURCE_SELECT_BIT 10
`define SEC_ZERO_HI 11
`define SEC_ZERO_LO 9
`define PRI_DEFAULT 12'h1B5
`define SEC_DEFAULT 12'h1DC
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define RST_HOLD_NS 100
`define RST_HOLD_CYC ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CFG_HOLD_NS 10
`define CFG_HOLD_CYC ((`CFG_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BRIDGE_WAIT_US 100
`define BRIDGE_WAIT_CYC ((`BRIDGE_WAIT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: verilog/boot_seq_pkg.sv
package boot_seq_pkg;
   typedef enum logic [10:0] {
      ST_IDLE = 11'h001,
      ST_RESET = 11'h002,
      ST_RELEASE = 11'h004,
      ST_HOLD = 11'h008,
      ST_WAIT_READY = 11'h010,
      ST_ENUM = 11'h020,
      ST_TX_CFG = 11'h040,
      ST_IO_WAIT = 11'h080,
      ST_RX_CFG = 11'h100,
      ST_LOGIC_WAIT = 11'h200,
      ST_DONE = 11'h400
   } state_type;
   typedef enum logic [2:0] {
      CMD_TX_PLL = 3'h1,
      CMD_IO_RELEASE = 3'h2,
      CMD_RX_PLL = 3'h3,
      CMD_TX_RELEASE = 3'h4,
      CMD_RX_RELEASE = 3'h5
   } command_type;
endpackage : boot_seq_pkg

// File: verilog/boot_pll_config_sequencer.sv
// Overview of operation
// R1: device holds all subsystems in reset while reset input is low.
// R2: reset stays asserted until the reference clock is reported stable.
// R3: primary pattern is driven on the pins before reset release.
// R4: device captures the primary pattern at reset release.
// R5: twenty-four bits go as primary then secondary twelve-bit sets.
// R6: secondary pattern is driven shortly after release and held continuously.
// R7: core PLL is set only from pins, never from registers.
// R8: device keeps I/O subsystems in reset while the core PLL settles.
// R9: device drops receive-stop once its core clock is stable.
// R10: host enumerates by placing ID on byte bus and granting one cycle.
// R11: bridge config, transmit PLL, wait 100us, then bridge I/O release.
// R12: receive PLL, wait 100us, then transmit then receive logic release.
// R13: device releases each bridge part only on its own register write.
// R14: after bridges run, host configures memory, expansion, interrupts, boots core.
// R15: primary bit 11 zero, bit 10 feedback select, then divider fields.
// R16: secondary upper three bits zero, low field is VCO filter setting.
// R17: 50 MHz to 250 MHz uses primary 1B5 and secondary 1DC.
// R18: device keeps receive-stop asserted from reset until core clock stable.
`timescale 1ns/1ps
`include "boot_seq_params.svh"

module boot_pll_config_sequencer #(
   parameter int WAIT_CYCLES = `BRIDGE_WAIT_CYC,
   parameter logic [`CFG_WIDTH-1:0] PRIMARY_PATTERN = `PRI_DEFAULT,
   parameter logic [`CFG_WIDTH-1:0] SECONDARY_PATTERN = `SEC_DEFAULT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic refClockStable,
   input wire logic [7:0] deviceId,
   input wire logic cmdReady,
   input wire logic host_rx_stop,
   output logic deviceRst_n,
   output logic [`CFG_WIDTH-1:0] pll_setup_pins,
   output logic [7:0] host_rx_byte,
   output logic host_grant,
   output logic cmdValid,
   output logic [2:0] cmdCode,
   output logic bridgeUp,
   output logic busy
);
   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if (WAIT_CYCLES < 1) begin : g_wait_check
      $error("WAIT_CYCLES must be at least one");
   end
   if (PRIMARY_PATTERN[`PRI_ZERO_BIT] != 1'b0) begin : g_primary_check
      $error("primary pattern top bit must be zero");
   end
   if (SECONDARY_PATTERN[`SEC_ZERO_HI:`SEC_ZERO_LO] != 3'h0) begin : g_secondary_check
      $error("secondary pattern upper bits must be zero");
   end

   localparam int RST_CYC = `RST_HOLD_CYC;
   localparam int CFG_CYC = `CFG_HOLD_CYC;

   boot_seq_pkg::state_type state_reg;
   logic [31:0] count_reg;
   logic stop_sync_reg;
   logic [31:0] stateCount;

   function automatic logic timer_done(input logic [31:0] cnt, input int limit);
      timer_done = (cnt >= 32'(limit - 1));
   endfunction : timer_done

   // ----------------------------------------
   // sequence state
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= boot_seq_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            boot_seq_pkg::ST_IDLE: begin
               if (start) begin
                  state_reg <= boot_seq_pkg::ST_RESET;
               end
            end
            boot_seq_pkg::ST_RESET: begin
               // clock must be steady and pulse long enough before release
               if (refClockStable && timer_done(stateCount, RST_CYC)) begin //R2
                  state_reg <= boot_seq_pkg::ST_RELEASE;
               end
            end
            boot_seq_pkg::ST_RELEASE: begin
               state_reg <= boot_seq_pkg::ST_HOLD;
            end
            boot_seq_pkg::ST_HOLD: begin
               if (timer_done(stateCount, CFG_CYC)) begin
                  state_reg <= boot_seq_pkg::ST_WAIT_READY;
               end
            end
            boot_seq_pkg::ST_WAIT_READY: begin
               if (!stop_sync_reg) begin //R9
                  state_reg <= boot_seq_pkg::ST_ENUM;
               end
            end
            boot_seq_pkg::ST_ENUM: begin
               state_reg <= boot_seq_pkg::ST_TX_CFG;
            end
            boot_seq_pkg::ST_TX_CFG: begin
               if (cmdValid && cmdReady && cmdCode == boot_seq_pkg::CMD_TX_PLL) begin
                  state_reg <= boot_seq_pkg::ST_IO_WAIT;
               end
            end
            boot_seq_pkg::ST_IO_WAIT: begin
               if (cmdValid && cmdReady && cmdCode == boot_seq_pkg::CMD_IO_RELEASE) begin
                  state_reg <= boot_seq_pkg::ST_RX_CFG;
               end
            end
            boot_seq_pkg::ST_RX_CFG: begin
               if (cmdValid && cmdReady && cmdCode == boot_seq_pkg::CMD_RX_PLL) begin
                  state_reg <= boot_seq_pkg::ST_LOGIC_WAIT;
               end
            end
            boot_seq_pkg::ST_LOGIC_WAIT: begin
               if (cmdValid && cmdReady && cmdCode == boot_seq_pkg::CMD_RX_RELEASE) begin
                  state_reg <= boot_seq_pkg::ST_DONE;
               end
            end
            boot_seq_pkg::ST_DONE: begin
               if (start) begin
                  state_reg <= boot_seq_pkg::ST_RESET;
               end
            end
            default: begin
               state_reg <= boot_seq_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // cycle counter, restarted on every state change
   // ----------------------------------------
   boot_seq_pkg::state_type lastState_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lastState_reg <= boot_seq_pkg::ST_IDLE;
         count_reg <= 32'h0;
      end else begin
         lastState_reg <= state_reg;
         if (state_reg != lastState_reg) begin
            count_reg <= 32'h1;
         end else if (count_reg != 32'hFFFFFFFF) begin
            count_reg <= count_reg + 32'h1;
         end
      end
   end

   // first cycle of a state reads zero, so no stale count leaks across states
   assign stateCount = (state_reg != lastState_reg) ? 32'h0 : count_reg;

   // ----------------------------------------
   // device pins
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_sync_reg <= 1'b1;
      end else begin
         stop_sync_reg <= host_rx_stop;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         deviceRst_n <= 1'b0;
      end else begin
         // device holds everything in reset while this is low
         deviceRst_n <= !(state_reg == boot_seq_pkg::ST_IDLE ||
            state_reg == boot_seq_pkg::ST_RESET); //R1
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_setup_pins <= PRIMARY_PATTERN;
      end else if (state_reg == boot_seq_pkg::ST_IDLE || state_reg == boot_seq_pkg::ST_RESET ||
         state_reg == boot_seq_pkg::ST_RELEASE) begin
         // primary set stands across the release edge for hold time
         pll_setup_pins <= PRIMARY_PATTERN; //R3 R4 R15
      end else if (state_reg == boot_seq_pkg::ST_HOLD && !timer_done(stateCount, CFG_CYC)) begin
         pll_setup_pins <= PRIMARY_PATTERN; //R5
      end else begin
         // secondary set held continuously; the core PLL has no register path
         pll_setup_pins <= SECONDARY_PATTERN; //R6 R7 R16 R17
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_rx_byte <= 8'h00;
         host_grant <= 1'b0;
      end else begin
         host_grant <= (state_reg == boot_seq_pkg::ST_ENUM); //R10
         if (state_reg == boot_seq_pkg::ST_WAIT_READY) begin
            host_rx_byte <= deviceId;
         end
      end
   end

   // ----------------------------------------
   // bridge bring-up command stream
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmdValid <= 1'b0;
         cmdCode <= 3'h0;
      end else if (cmdValid && !cmdReady) begin
         cmdValid <= 1'b1;
      end else begin
         cmdValid <= 1'b0;
         case (state_reg)
            boot_seq_pkg::ST_TX_CFG: begin
               if (!(cmdValid && cmdCode == boot_seq_pkg::CMD_TX_PLL)) begin
                  cmdValid <= 1'b1;
                  cmdCode <= boot_seq_pkg::CMD_TX_PLL;
               end
            end
            boot_seq_pkg::ST_IO_WAIT: begin
               // settle time counted from the transmit PLL write
               if (timer_done(stateCount, WAIT_CYCLES) &&
                  cmdCode != boot_seq_pkg::CMD_IO_RELEASE) begin //R11
                  cmdValid <= 1'b1;
                  cmdCode <= boot_seq_pkg::CMD_IO_RELEASE;
               end
            end
            boot_seq_pkg::ST_RX_CFG: begin
               if (cmdCode != boot_seq_pkg::CMD_RX_PLL) begin
                  cmdValid <= 1'b1;
                  cmdCode <= boot_seq_pkg::CMD_RX_PLL;
               end
            end
            boot_seq_pkg::ST_LOGIC_WAIT: begin
               if (timer_done(stateCount, WAIT_CYCLES) &&
                  cmdCode == boot_seq_pkg::CMD_RX_PLL) begin //R12 R13
                  cmdValid <= 1'b1;
                  cmdCode <= boot_seq_pkg::CMD_TX_RELEASE;
               end else if (cmdCode == boot_seq_pkg::CMD_TX_RELEASE) begin
                  cmdValid <= 1'b1;
                  cmdCode <= boot_seq_pkg::CMD_RX_RELEASE;
               end
            end
            default: begin
               cmdCode <= cmdCode;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bridgeUp <= 1'b0;
         busy <= 1'b0;
      end else begin
         // after this, memory and core setup belong to the user side
         bridgeUp <= (state_reg == boot_seq_pkg::ST_DONE); //R14
         busy <= (state_reg != boot_seq_pkg::ST_IDLE && state_reg != boot_seq_pkg::ST_DONE);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_grant;
      host_grant ##1 !host_grant;
   endsequence

   property p_rst_low;
      @(posedge clk) disable iff (!rst_n)
      (state_reg == boot_seq_pkg::ST_RESET) |=> !deviceRst_n;
   endproperty
   a_rst_low: assert property (p_rst_low) else $error("device reset not held"); //R1

   property p_clock_first;
      @(posedge clk) disable iff (!rst_n)
      $rose(deviceRst_n) |-> $past(refClockStable, 2);
   endproperty
   a_clock_first: assert property (p_clock_first) else $error("released before clock"); //R2

   property p_primary_at_release;
      @(posedge clk) disable iff (!rst_n)
      $rose(deviceRst_n) |-> pll_setup_pins == PRIMARY_PATTERN &&
         $past(pll_setup_pins) == PRIMARY_PATTERN;
   endproperty
   a_primary_at_release: assert property (p_primary_at_release) else $error("primary not held"); //R3

   property p_secondary;
      @(posedge clk) disable iff (!rst_n)
      (state_reg == boot_seq_pkg::ST_WAIT_READY) |=> pll_setup_pins == SECONDARY_PATTERN;
   endproperty
   a_secondary: assert property (p_secondary) else $error("secondary not driven"); //R6

   property p_grant_one;
      @(posedge clk) disable iff (!rst_n)
      $rose(host_grant) |-> s_grant and (host_rx_byte == deviceId);
   endproperty
   a_grant_one: assert property (p_grant_one) else $error("grant not one cycle"); //R10

   property p_grant_ready;
      @(posedge clk) disable iff (!rst_n)
      $rose(host_grant) |-> $past(!stop_sync_reg, 2);
   endproperty
   a_grant_ready: assert property (p_grant_ready) else $error("grant before ready"); //R9

   property p_io_order;
      @(posedge clk) disable iff (!rst_n)
      ($rose(cmdValid) && cmdCode == boot_seq_pkg::CMD_IO_RELEASE) |->
         (stateCount >= 32'(WAIT_CYCLES));
   endproperty
   a_io_order: assert property (p_io_order) else $error("bridge io released early"); //R11

   property p_rx_after_tx;
      @(posedge clk) disable iff (!rst_n)
      $rose(cmdValid && cmdCode == boot_seq_pkg::CMD_RX_RELEASE) |->
         $past(cmdCode) == boot_seq_pkg::CMD_TX_RELEASE;
   endproperty
   a_rx_after_tx: assert property (p_rx_after_tx) else $error("rx released before tx"); //R12

endmodule : boot_pll_config_sequencer

// File: tb/device_model.sv
`timescale 1ns/1ps
// ------------------------------
// behavioural accelerator reset and host port
// ------------------------------
module device_model #(
   parameter int SETTLE = 8
) (
   input wire logic clk,
   input wire logic deviceRst_n,
   input wire logic [11:0] pll_setup_pins,
   input wire logic [7:0] host_rx_byte,
   input wire logic host_grant,
   output logic host_rx_stop,
   output logic [11:0] primaryCfg,
   output logic [7:0] enumId,
   output int grantCount
);
   int settleCnt;
   initial grantCount = 0;
   // host port stays stopped until the core clock has settled
   always_ff @(posedge clk or negedge deviceRst_n) begin
      if (!deviceRst_n) begin
         host_rx_stop <= 1'b1;
         settleCnt <= 0;
      end else if (settleCnt < SETTLE) begin
         settleCnt <= settleCnt + 1;
      end else begin
         host_rx_stop <= 1'b0;
      end
   end
   // core pll ratio comes only from the pins, latched at reset release
   always @(posedge deviceRst_n) begin
      primaryCfg = pll_setup_pins;
   end
   always @(posedge clk) begin
      if (deviceRst_n && host_grant) begin
         enumId <= host_rx_byte;
         grantCount <= grantCount + 1;
      end
   end
endmodule : device_model

// File: tb/boot_pll_config_sequencer_test.sv
`timescale 1ns/1ps
module boot_pll_config_sequencer_test;
   localparam int WAIT = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic start = 1'b0;
   logic refClockStable = 1'b0;
   logic cmdReady = 1'b0;
   logic [7:0] deviceId = 8'h00;
   logic host_rx_stop, deviceRst_n, host_grant, cmdValid, bridgeUp, busy;
   logic [11:0] pll_setup_pins, primaryCfg;
   logic [7:0] host_rx_byte, enumId;
   logic [2:0] cmdCode;
   int grantCount, n, lastAcc;
   int badCount = 0;
   int checksDone = 0;
   int cyc = 0;
   int seed = 32'hBFC7292A;
   int expCmds[$];

   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   boot_pll_config_sequencer #(.WAIT_CYCLES(WAIT)) i_boot_pll_config_sequencer (
      .clk(clk), .rst_n(rst_n), .start(start), .refClockStable(refClockStable),
      .deviceId(deviceId), .cmdReady(cmdReady), .host_rx_stop(host_rx_stop),
      .deviceRst_n(deviceRst_n), .pll_setup_pins(pll_setup_pins),
      .host_rx_byte(host_rx_byte), .host_grant(host_grant), .cmdValid(cmdValid),
      .cmdCode(cmdCode), .bridgeUp(bridgeUp), .busy(busy));

   device_model i_device_model (
      .clk(clk), .deviceRst_n(deviceRst_n), .pll_setup_pins(pll_setup_pins),
      .host_rx_byte(host_rx_byte), .host_grant(host_grant), .host_rx_stop(host_rx_stop),
      .primaryCfg(primaryCfg), .enumId(enumId), .grantCount(grantCount));

   // ------------------------------
   // checking and closing
   // ------------------------------
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      checksDone++;
      if (seen !== exp) begin
         badCount++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic endSim;
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : endSim

   task automatic hang;
      badCount++;
      $display("[ERR] %0t wait ran out", $time);
      endSim();
   endtask : hang

   // one boot; the far side may report its clock late, or the run is cut by reset
   task automatic runBoot(input bit slowClk, input bit abortRun);
      int t;
      @(posedge clk);
      deviceId <= 8'($random(seed));
      start <= 1'b1;
      refClockStable <= !slowClk;
      @(posedge clk);
      start <= 1'b0;
      // a restart from a finished boot first has to pull the device reset low
      t = 0;
      while (deviceRst_n !== 1'b0) begin
         @(negedge clk);
         t++;
         if (t > 100) hang();
      end
      t = 0;
      if (slowClk) begin
         repeat (15) begin
            @(negedge clk);
            t++;
            check(deviceRst_n, 1'b0);
            check(pll_setup_pins, 12'h1B5);
         end
         @(posedge clk);
         refClockStable <= 1'b1;
      end
      while (deviceRst_n !== 1'b1) begin
         @(negedge clk);
         t++;
         if (t > 100) hang();
      end
      check(busy, 1'b1);
      // t counts from when this boot first sees the device reset low until it rises
      check(t >= 10, 1'b1);
      check(primaryCfg, 12'h1B5);
      check(primaryCfg[11], 1'b0);
      repeat (2) @(negedge clk);
      check(pll_setup_pins, 12'h1DC);
      check(pll_setup_pins[11:9], 3'h0);
      n = grantCount;
      t = 0;
      while (host_grant !== 1'b1) begin
         @(negedge clk);
         t++;
         if (t > 100) hang();
      end
      check(host_rx_stop, 1'b0);
      check(host_rx_byte, deviceId);
      @(negedge clk);
      check(host_grant, 1'b0);
      check(12'(grantCount - n), 12'h001);
      check(enumId, deviceId);
      if (abortRun) begin
         @(posedge clk);
         rst_n <= 1'b0;
         @(negedge clk);
         check(deviceRst_n, 1'b0);
         check(pll_setup_pins, 12'h1B5);
         check(cmdValid, 1'b0);
         check(host_rx_stop, 1'b1);
         repeat (2) @(posedge clk);
         rst_n <= 1'b1;
         $display("aborted boot done");
         return;
      end
      expCmds = '{1, 2, 3, 4, 5};
      lastAcc = cyc;
      while (expCmds.size() > 0) begin
         t = 0;
         while (cmdValid !== 1'b1) begin
            @(negedge clk);
            t++;
            if (t > WAIT + 100) hang();
         end
         check(cmdCode, 12'(expCmds[0]));
         n = $random(seed) & 3;
         repeat (n) begin
            @(negedge clk);
            check(cmdValid, 1'b1);
            check(cmdCode, 12'(expCmds[0]));
         end
         @(posedge clk);
         cmdReady <= 1'b1;
         @(posedge clk);
         cmdReady <= 1'b0;
         if (expCmds[0] == 2 || expCmds[0] == 4) check(cyc - lastAcc >= WAIT, 1'b1);
         lastAcc = cyc;
         void'(expCmds.pop_front());
         // the accept edge drops cmdValid, or launches the receive release at once; settled only here
         @(negedge clk);
      end
      t = 0;
      while (bridgeUp !== 1'b1) begin
         @(negedge clk);
         t++;
         if (t > 20) hang();
      end
      check(bridgeUp, 1'b1);
      $display("full boot done");
   endtask : runBoot

   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      runBoot(1'b1, 1'b0);
      runBoot(1'b0, 1'b1);
      runBoot(1'b0, 1'b0);
      endSim();
   end
endmodule : boot_pll_config_sequencer_test
